// ### logic/pd_tx_token_framer_irq.sv
// Purpose: transmit token interpreter and event latch register
// Assumes: register accesses are one-cycle strobes on SYS_CLK
// Notes: line inputs are asynchronous and pass three flops
`timescale 1ns/1ps
`include "pd_tx_defs.svh"
module pd_tx_token_framer_irq import pd_tx_pkg::*; #(
	parameter int TX_DEPTH = `TX_DEPTH_DEF,
	parameter int BIT_DIV = `PD_UI_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// register access
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// transmit control
	input wire logic TX_START,
	// analog status
	input wire line_in_s LINE_IN,
	// receive side
	input wire logic RX_CRC_DONE,
	input wire logic RX_FULL,
	input wire logic [7:0] RX_DATA,
	output logic RX_POP,
	// cc line
	output logic CC_TX_DATA,
	output logic CC_TX_EN
);
	localparam int PW = $clog2(TX_DEPTH);
	localparam int CW = $clog2(TX_DEPTH + 1);

	generate
		if (TX_DEPTH < 2) begin : g_chk
			$error("TX_DEPTH must be at least two");
		end
	endgenerate

	// ****************************************
	// line input synchronisers
	// ****************************************
	logic [5:0] s1_q, s2_q, s3_q, st_q;
	logic [5:0] agree, chg;

	assign agree = ~(s2_q ^ s3_q);
	assign chg = agree & (s3_q ^ st_q);

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			s1_q <= 6'h00;
			s2_q <= 6'h00;
			s3_q <= 6'h00;
			st_q <= 6'h00;
		end else begin
			s1_q <= LINE_IN;
			s2_q <= s1_q;
			s3_q <= s2_q;
			st_q <= (st_q & ~agree) | (s3_q & agree);
		end
	end

	// ****************************************
	// transmit fifo
	// ****************************************
	logic [7:0] mem [TX_DEPTH];
	logic [PW-1:0] wp_q, rp_q;
	logic [CW-1:0] cnt_q;
	logic full, empty, push, pop, start_tok, fifo_wr;
	logic [7:0] head;

	assign full = cnt_q == CW'(TX_DEPTH);
	assign empty = cnt_q == '0;
	assign head = mem[rp_q];
	assign fifo_wr = REG_WR && REG_ADDR == `REG_FIFO;
	assign start_tok = (REG_WDATA & `TOK_START_MASK) == `TOK_START_VAL;
	assign push = fifo_wr && !start_tok && !full;

	always_ff @(posedge SYS_CLK) begin
		if (push) begin
			mem[wp_q] <= REG_WDATA;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q == PW'(TX_DEPTH - 1) ? '0 : wp_q + PW'(1);
			end
			if (pop) begin
				rp_q <= rp_q == PW'(TX_DEPTH - 1) ? '0 : rp_q + PW'(1);
			end
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end

	// ****************************************
	// token interpreter
	// ****************************************
	tx_state_e state_q;
	sym_t sym_q, sym;
	logic [7:0] byte_q;
	logic [4:0] left_q;
	logic [2:0] nib_q;
	logic [31:0] crc_q, crc_out;
	logic [3:0] crc_nib;
	logic ser_ready, ser_go, ser_bit, start_req, coll, fetch, is_pack;

	assign start_req = TX_START || (fifo_wr && start_tok);
	assign coll = start_req && state_q == S_IDLE && st_q[`LI_ACT];
	assign fetch = state_q == S_FETCH && !empty && ser_ready;
	assign is_pack = (head & `TOK_PACK_MASK) == `TOK_PACK_VAL;
	assign pop = fetch || (state_q == S_BYTE && !empty);
	assign crc_out = ~crc_q;
	assign crc_nib = 4'(crc_out >> {nib_q, 2'b00});

	function automatic sym_t enc4b5b(input logic [3:0] n);
		case (n)
			4'h0: enc4b5b = 5'h1E;
			4'h1: enc4b5b = 5'h09;
			4'h2: enc4b5b = 5'h14;
			4'h3: enc4b5b = 5'h15;
			4'h4: enc4b5b = 5'h0A;
			4'h5: enc4b5b = 5'h0B;
			4'h6: enc4b5b = 5'h0E;
			4'h7: enc4b5b = 5'h0F;
			4'h8: enc4b5b = 5'h12;
			4'h9: enc4b5b = 5'h13;
			4'hA: enc4b5b = 5'h16;
			4'hB: enc4b5b = 5'h17;
			4'hC: enc4b5b = 5'h1A;
			4'hD: enc4b5b = 5'h1B;
			4'hE: enc4b5b = 5'h1C;
			default: enc4b5b = 5'h1D;
		endcase
	endfunction

	function automatic logic [31:0] crc4(input logic [31:0] c,
		input logic [3:0] n);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = (r[0] ^ n[i]) ? (r >> 1) ^ `CRC_POLY : r >> 1;
		end
		crc4 = r;
	endfunction

	always_comb begin
		case (state_q)
			S_LO: sym = enc4b5b(byte_q[3:0]);
			S_HI: sym = enc4b5b(byte_q[7:4]);
			S_CRC: sym = enc4b5b(crc_nib);
			default: sym = sym_q;
		endcase
	end

	assign ser_go = ser_ready && (state_q == S_SEND || state_q == S_LO ||
		state_q == S_HI || state_q == S_CRC);

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			state_q <= S_IDLE;
			sym_q <= `K_EOP;
			byte_q <= 8'h00;
			left_q <= 5'h00;
			nib_q <= 3'h0;
			CC_TX_EN <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (start_req && !coll) begin
						state_q <= S_FETCH;
						CC_TX_EN <= 1'b1;
					end
				end
				S_FETCH: begin
					if (fetch) begin
						state_q <= S_SEND;
						case (head)
							`TOK_SYNC1: sym_q <= `K_SYNC1;
							`TOK_SYNC2: sym_q <= `K_SYNC2;
							`TOK_SYNC3: sym_q <= `K_SYNC3;
							`TOK_RST1: sym_q <= `K_RST1;
							`TOK_RST2: sym_q <= `K_RST2;
							`TOK_EOP: sym_q <= `K_EOP;
							`TOK_CRC: begin
								nib_q <= 3'h0;
								state_q <= S_CRC;
							end
							`TOK_OFF: begin
								CC_TX_EN <= 1'b0;
								state_q <= S_IDLE;
							end
							default: begin
								left_q <= head[4:0];
								if (!is_pack || head[4:0] == 5'h00) begin
									state_q <= S_FETCH;
								end else begin
									state_q <= S_BYTE;
								end
							end
						endcase
					end
				end
				S_SEND: begin
					if (ser_ready) begin
						state_q <= S_FETCH;
					end
				end
				S_BYTE: begin
					if (!empty) begin
						byte_q <= head;
						state_q <= S_LO;
					end
				end
				S_LO: begin
					if (ser_ready) begin
						state_q <= S_HI;
					end
				end
				S_HI: begin
					if (ser_ready) begin
						left_q <= left_q - 5'h01;
						state_q <= left_q == 5'h01 ? S_FETCH : S_BYTE;
					end
				end
				S_CRC: begin
					if (ser_ready) begin
						nib_q <= nib_q + 3'h1;
						if (nib_q == `CRC_LAST_NIB) begin
							state_q <= S_FETCH;
						end
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// crc restarts at each sync symbol, covers payload nibbles
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			crc_q <= `CRC_INIT;
		end else if (fetch && (head == `TOK_SYNC1 ||
			head == `TOK_SYNC2 || head == `TOK_SYNC3)) begin
			crc_q <= `CRC_INIT;
		end else if (ser_go && state_q == S_LO) begin
			crc_q <= crc4(crc_q, byte_q[3:0]);
		end else if (ser_go && state_q == S_HI) begin
			crc_q <= crc4(crc_q, byte_q[7:4]);
		end
	end

	pd_symbol_serializer #(
		.BIT_DIV(BIT_DIV)
	) u_ser (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.go(ser_go),
		.sym(sym),
		.ready(ser_ready),
		.bit_out(ser_bit)
	);

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			CC_TX_DATA <= 1'b0;
		end else begin
			CC_TX_DATA <= ser_bit;
		end
	end

	// ****************************************
	// event latch and register reads
	// ****************************************
	logic [7:0] ev_q, set_ev;
	logic full_q, rxf_q, ev_rd;

	assign ev_rd = REG_RD && REG_ADDR == `REG_EVENT;

	always_comb begin
		set_ev = `EV_RESET;
		set_ev[`EV_VBUS] = chg[`LI_VBUS];
		set_ev[`EV_ACT] = chg[`LI_ACT];
		set_ev[`EV_COMP] = chg[`LI_COMP];
		set_ev[`EV_CRC] = RX_CRC_DONE;
		set_ev[`EV_ALERT] = (full && !full_q) || (RX_FULL && !rxf_q);
		set_ev[`EV_WAKE] = chg[`LI_WAKE] && s3_q[`LI_WAKE];
		set_ev[`EV_COLL] = coll;
		set_ev[`EV_LEVEL] = chg[`LI_LEVEL_HI] || chg[`LI_LEVEL_LO];
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			ev_q <= `EV_RESET;
			full_q <= 1'b0;
			rxf_q <= 1'b0;
		end else begin
			full_q <= full;
			rxf_q <= RX_FULL;
			ev_q <= (ev_rd ? `EV_RESET : ev_q) | set_ev;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			REG_RDATA <= 8'h00;
			RX_POP <= 1'b0;
		end else begin
			RX_POP <= REG_RD && REG_ADDR == `REG_FIFO;
			if (ev_rd) begin
				REG_RDATA <= ev_q;
			end else if (REG_RD && REG_ADDR == `REG_FIFO) begin
				REG_RDATA <= RX_DATA;
			end else if (REG_RD) begin
				REG_RDATA <= 8'h00;
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);

	a_push_count: assert property (
		push && !pop |=> cnt_q == $past(cnt_q) + CW'(1))
		else $error("fifo write did not add one byte");
	a_start_noq: assert property (
		fifo_wr && start_tok && !pop |=> cnt_q == $past(cnt_q))
		else $error("start token was queued");
	a_coll_abort: assert property (
		coll |=> state_q == S_IDLE && ev_q[`EV_COLL] && !CC_TX_EN)
		else $error("collision did not abandon transmit");
	a_vbus_flag: assert property (
		chg[`LI_VBUS] |=> ev_q[`EV_VBUS])
		else $error("vbus change not latched");
	a_read_clear: assert property (
		ev_rd && set_ev == `EV_RESET |=>
		ev_q == `EV_RESET && REG_RDATA == $past(ev_q))
		else $error("event read did not return and clear");
	a_driver_off: assert property (
		fetch && head == `TOK_OFF |=> !CC_TX_EN && state_q == S_IDLE)
		else $error("driver off token ignored");
	a_sync_sym: assert property (
		fetch && head == `TOK_SYNC2 |=> sym_q == `K_SYNC2 ##1 !ser_ready)
		else $error("sync-2 not sent");
	a_pack_len: assert property (
		fetch && is_pack && head[4:0] != 5'h00 |=>
		state_q == S_BYTE && left_q == $past(head[4:0]))
		else $error("packed count not taken");
	a_nib_order: assert property (
		state_q == S_LO && ser_ready |=> state_q == S_HI)
		else $error("high nibble did not follow low");
	a_crc_len: assert property (
		state_q == S_CRC && nib_q == `CRC_LAST_NIB && ser_ready |=>
		state_q == S_FETCH)
		else $error("crc not eight nibbles");
	a_alert_flag: assert property (
		full && !full_q |=> ev_q[`EV_ALERT])
		else $error("full alert not latched");

	c_packet: cover property (fetch && head == `TOK_SYNC1 ##[1:1000]
		state_q == S_CRC);
	c_collision: cover property (coll);
	c_off: cover property (fetch && head == `TOK_OFF);

endmodule

// ### logic/pd_tx_defs.svh
// Purpose: named constants for the token framer and event latch
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef PD_TX_DEFS_SVH
`define PD_TX_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define REG_EVENT 8'h42
`define REG_FIFO 8'h43

// ****************************************
// event bit positions
// ****************************************
`define EV_VBUS 7
`define EV_ACT 6
`define EV_COMP 5
`define EV_CRC 4
`define EV_ALERT 3
`define EV_WAKE 2
`define EV_COLL 1
`define EV_LEVEL 0
`define EV_RESET 8'h00

// ****************************************
// line input bit positions
// ****************************************
`define LI_VBUS 5
`define LI_ACT 4
`define LI_COMP 3
`define LI_WAKE 2
`define LI_LEVEL_HI 1
`define LI_LEVEL_LO 0

// ****************************************
// transmit tokens
// ****************************************
`define TOK_START_MASK 8'hE1
`define TOK_START_VAL 8'hA1
`define TOK_PACK_MASK 8'hE0
`define TOK_PACK_VAL 8'h80
`define TOK_SYNC1 8'h12
`define TOK_SYNC2 8'h13
`define TOK_SYNC3 8'h1B
`define TOK_RST1 8'h15
`define TOK_RST2 8'h16
`define TOK_EOP 8'h14
`define TOK_CRC 8'hFF
`define TOK_OFF 8'hFE

// ****************************************
// line symbols
// ****************************************
`define K_SYNC1 5'h18
`define K_SYNC2 5'h11
`define K_SYNC3 5'h06
`define K_RST1 5'h07
`define K_RST2 5'h19
`define K_EOP 5'h0D
`define SYM_BITS 3'h5

// ****************************************
// crc and timing
// ****************************************
`define CRC_POLY 32'hEDB8_8320
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_LAST_NIB 3'h7
`define CLK_PERIOD_NS 8
`define PD_UI_NS 3333
`define TX_DEPTH_DEF 48

`endif

// ### logic/pd_tx_pkg.sv
// Purpose: shared types of the token framer
// Assumes: constants come from pd_tx_defs.svh
// Notes: types only
package pd_tx_pkg;

	typedef logic [4:0] sym_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_FETCH = 3'b001,
		S_SEND = 3'b010,
		S_BYTE = 3'b011,
		S_LO = 3'b100,
		S_HI = 3'b101,
		S_CRC = 3'b110
	} tx_state_e;

	typedef struct packed {
		logic vbus;
		logic activity;
		logic comp;
		logic wake;
		logic [1:0] level;
	} line_in_s;

endpackage

// ### logic/pd_symbol_serializer.sv
// Purpose: shifts one 5-bit line symbol out, bit 0 first
// Assumes: go only while ready is high
// Notes: one bit per BIT_DIV clocks
`timescale 1ns/1ps
`include "pd_tx_defs.svh"
module pd_symbol_serializer import pd_tx_pkg::*; #(
	parameter int BIT_DIV = `PD_UI_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// symbol in
	input wire logic go,
	input wire sym_t sym,
	output logic ready,
	// line bit
	output logic bit_out
);
	localparam int DW = $clog2(BIT_DIV + 1);

	logic [4:0] sh_q;
	logic [2:0] left_q;
	logic [DW-1:0] div_q;

	generate
		if (BIT_DIV < 1) begin : g_chk
			$error("BIT_DIV must be at least one");
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ready <= 1'b1;
			bit_out <= 1'b0;
			sh_q <= 5'h00;
			left_q <= 3'h0;
			div_q <= '0;
		end else if (ready) begin
			if (go) begin
				bit_out <= sym[0];
				sh_q <= {1'b0, sym[4:1]};
				left_q <= `SYM_BITS - 3'h1;
				div_q <= DW'(BIT_DIV - 1);
				ready <= 1'b0;
			end
		end else if (div_q != '0) begin
			div_q <= div_q - DW'(1);
		end else if (left_q != 3'h0) begin
			bit_out <= sh_q[0];
			sh_q <= {1'b0, sh_q[4:1]};
			left_q <= left_q - 3'h1;
			div_q <= DW'(BIT_DIV - 1);
		end else begin
			ready <= 1'b1;
		end
	end

endmodule

// ### tb/pd_cc_partner.sv
// Purpose: cc line receiver standing in for the port partner
// Assumes: each bit lasts BIT_DIV clocks; idle and gaps are shorter
// Notes: reports the decoded bits of a frame when the driver turns off
`timescale 1ns/1ps
module pd_cc_partner #(
	parameter int BIT_DIV = 4
) (
	// line
	input wire logic clk,
	input wire logic cc_data,
	input wire logic cc_en,
	// frame report
	output logic done,
	output logic [255:0] bits,
	output logic [8:0] nbits
);
	logic last = 1'b0;
	logic en_q = 1'b0;
	int run = 0;
	initial begin
		done = 1'b0;
		bits = '0;
		nbits = '0;
	end
	// ****************************************
	// run-length decode
	// ****************************************
	always @(posedge clk) begin
		done <= 1'b0;
		if (en_q && cc_en && cc_data == last) begin
			run++;
		end else if (en_q) begin
			// floor drops idle and gap cycles shorter than a bit
			for (int k = 0; k < run / BIT_DIV; k++) begin
				bits[nbits] = last;
				nbits++;
			end
			run = 1;
			done <= !cc_en;
		end else begin
			bits = '0;
			nbits = '0;
			run = 1;
		end
		last = cc_data;
		en_q = cc_en;
	end
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench of the token framer and event latch
// Assumes: short bit divider and fifo depth keep the run brief
// Notes: expected reads and frames are queued; watchers compare
`timescale 1ns/1ps
`include "pd_tx_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	fails++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb import pd_tx_pkg::*;;
	localparam int BD = 4;
	localparam int DEPTH = 12;
	localparam sym_t ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
		5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	typedef struct packed {
		logic [255:0] bits;
		logic [8:0] n;
	} frame_s;
	logic sys_clk, rstn, reg_wr, reg_rd, tx_start, rx_crc_done, rx_full;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_data, b;
	logic rx_pop, cc_data, cc_en, p_done, rd_seen;
	logic [255:0] p_bits, eb;
	logic [31:0] crc_e;
	logic [8:0] p_n, en, rx_e;
	line_in_s line_in;
	logic [8:0] rq[$];
	frame_s fq[$];
	frame_s fe;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;

	pd_tx_token_framer_irq #(.TX_DEPTH(DEPTH), .BIT_DIV(BD)) u_dut (
		.SYS_CLK(sys_clk), .RSTN(rstn), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.TX_START(tx_start), .LINE_IN(line_in), .RX_CRC_DONE(rx_crc_done),
		.RX_FULL(rx_full), .RX_DATA(rx_data), .RX_POP(rx_pop),
		.CC_TX_DATA(cc_data), .CC_TX_EN(cc_en));
	pd_cc_partner #(.BIT_DIV(BD)) u_far (.clk(sys_clk), .cc_data(cc_data),
		.cc_en(cc_en), .done(p_done), .bits(p_bits), .nbits(p_n));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ****************************************
	// watchers and timeout
	// ****************************************
	always @(posedge sys_clk) begin
		rd_seen <= reg_rd;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			close_out();
		end
	end
	always @(negedge sys_clk) begin
		if (rd_seen === 1'b1) begin
			rx_e = rq.pop_front();
			`CHK({rx_pop, reg_rdata}, rx_e)
		end
		if (p_done === 1'b1) begin
			fe = fq.size() ? fq.pop_front() : '0;
			`CHK(p_n, fe.n)
			`CHK(p_bits, fe.bits)
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [3:0] n);
		for (int i = 0; i < 4; i++) begin
			c = (c[0] ^ n[i]) ? (c >> 1) ^ `CRC_POLY : c >> 1;
		end
		return c;
	endfunction
	task automatic close_out();
		// a frame or read never seen counts against the run
		if (fq.size() != 0 || rq.size() != 0) begin
			fails++;
		end
		$display("counts: %0d checked, %0d failed", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] d,
		input logic crc = 1'b0);
		@(negedge sys_clk);
		rq.push_back({a == `REG_FIFO, d});
		reg_rd = 1'b1;
		reg_addr = a;
		rx_crc_done = crc;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		rx_crc_done = 1'b0;
	endtask
	task automatic put_sym(input sym_t s);
		for (int k = 0; k < 5; k++) begin
			eb[en] = s[k];
			en++;
		end
	endtask
	task automatic tok(input logic [7:0] t, input sym_t s);
		wr_reg(`REG_FIFO, t);
		put_sym(s);
	endtask
	task automatic pulse_start();
		@(negedge sys_clk);
		tx_start = 1'b1;
		@(negedge sys_clk);
		tx_start = 1'b0;
	endtask
	task automatic run_frame(input logic by_token);
		fq.push_back({eb, en});
		if (by_token) begin
			wr_reg(`REG_FIFO, `TOK_START_VAL);
		end else begin
			pulse_start();
		end
		`CHK(cc_en, 1'b1)
		for (int t = 0; t < 4000 && cc_en !== 1'b0; t++) begin
			@(negedge sys_clk);
		end
		repeat (2) @(negedge sys_clk);
		eb = '0;
		en = '0;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		tx_start = 1'b0;
		rx_crc_done = 1'b0;
		rx_full = 1'b0;
		rx_data = '0;
		line_in = '0;
		eb = '0;
		en = '0;
		void'($urandom(21139));
		repeat (8) @(negedge sys_clk);
		rstn = 1'b1;
		`CHK(cc_en, 1'b0)
		rd_reg(`REG_EVENT, `EV_RESET);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			if (i == `EV_COLL) continue;
			case (i)
				`EV_LEVEL: line_in.level ^= 2'($urandom_range(3, 1));
				`EV_WAKE: line_in.wake = 1'b1;
				`EV_ALERT: rx_full = 1'b1;
				`EV_CRC: rx_crc_done = 1'b1;
				`EV_COMP: line_in.comp = 1'b1;
				`EV_ACT: line_in.activity = 1'b1;
				default: line_in.vbus = 1'b1;
			endcase
			@(negedge sys_clk);
			rx_crc_done = 1'b0;
			repeat (6) @(negedge sys_clk);
			rd_reg(`REG_EVENT, 8'(1 << i));
		end
		line_in.activity = 1'b0;
		line_in.wake = 1'b0;
		rx_full = 1'b0;
		repeat (6) @(negedge sys_clk);
		rd_reg(`REG_EVENT, 8'h40, 1'b1);
		rd_reg(`REG_EVENT, 8'h10);
		rd_reg(`REG_EVENT, 8'h00);
		$display("test events done");
		rx_data = 8'($urandom);
		rd_reg(`REG_FIFO, rx_data);
		rd_reg(8'h44, 8'h00);
		wr_reg(`REG_EVENT, 8'hFF);
		rd_reg(`REG_EVENT, 8'h00);
		$display("test port done");
		repeat (3) tok(`TOK_SYNC1, `K_SYNC1);
		tok(`TOK_SYNC2, `K_SYNC2);
		wr_reg(`REG_FIFO, 8'h82);
		crc_e = `CRC_INIT;
		repeat (2) begin
			b = 8'($urandom);
			// a start pattern would never be queued
			if ((b & `TOK_START_MASK) == `TOK_START_VAL) begin
				b[0] = 1'b0;
			end
			wr_reg(`REG_FIFO, b);
			put_sym(ENC[b[3:0]]);
			put_sym(ENC[b[7:4]]);
			crc_e = crc_step(crc_step(crc_e, b[3:0]), b[7:4]);
		end
		wr_reg(`REG_FIFO, `TOK_CRC);
		crc_e = ~crc_e;
		for (int k = 0; k < 8; k++) begin
			put_sym(ENC[crc_e[4*k +: 4]]);
		end
		tok(`TOK_EOP, `K_EOP);
		wr_reg(`REG_FIFO, `TOK_OFF);
		run_frame(1'b1);
		$display("test packet frame done");
		tok(`TOK_SYNC3, `K_SYNC3);
		tok(`TOK_RST1, `K_RST1);
		tok(`TOK_RST2, `K_RST2);
		tok(`TOK_EOP, `K_EOP);
		wr_reg(`REG_FIFO, `TOK_OFF);
		run_frame(1'b0);
		$display("test ordered set frame done");
		line_in.activity = 1'b1;
		repeat (6) @(negedge sys_clk);
		rd_reg(`REG_EVENT, 8'h40);
		pulse_start();
		`CHK(cc_en, 1'b0)
		rd_reg(`REG_EVENT, 8'h02);
		line_in.activity = 1'b0;
		repeat (6) @(negedge sys_clk);
		rd_reg(`REG_EVENT, 8'h40);
		$display("test collision done");
		repeat (DEPTH - 1) tok(`TOK_EOP, `K_EOP);
		wr_reg(`REG_FIFO, `TOK_OFF);
		wr_reg(`REG_FIFO, `TOK_SYNC1);
		rd_reg(`REG_EVENT, 8'h08);
		run_frame(1'b0);
		$display("test full fifo done");
		close_out();
	end
endmodule
